//--- hw/rtc_calendar.sv
// BCD clock and calendar counters with byte write port
`timescale 1ns/1ns
module rtc_calendar (
   input  wire logic              mclk,
   input  wire logic              arst_n,
   input  wire logic              tick,
   input  wire logic              wr_en,
   input  wire logic [2:0]        wr_addr,
   input  wire logic [7:0]        wr_data,
   output rtc_pkg::rtc_time_t     time_q
);

   // ***********************************************************
   // BCD helpers
   // ***********************************************************
   function automatic logic [7:0] bcd_next(input logic [7:0] v,
                                           input logic [7:0] maxv,
                                           input logic [7:0] minv);
      if (v == maxv) begin
         bcd_next = minv;
      end else if (v[3:0] == 4'h9) begin
         bcd_next = {v[7:4] + 4'h1, 4'h0};
      end else begin
         bcd_next = {v[7:4], v[3:0] + 4'h1};
      end
   endfunction

   function automatic logic is_leap(input logic [7:0] y);
      if (y[4] == 1'b0) begin
         is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
      end else begin
         is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
      end
   endfunction

   function automatic logic [7:0] month_days(input logic [7:0] m,
                                             input logic [7:0] y);
      case (m)
         rtc_pkg::FEB: begin
            month_days = is_leap(y) ? rtc_pkg::DAYS_LEAP
                                    : rtc_pkg::DAYS_FEB;
         end
         8'h04, 8'h06, 8'h09, 8'h11: begin
            month_days = rtc_pkg::DAYS_SHORT;
         end
         default: begin
            month_days = rtc_pkg::DAYS_LONG;
         end
      endcase
   endfunction

   // ***********************************************************
   // Carry chain
   // ***********************************************************
   rtc_pkg::rtc_time_t t_reg;
   rtc_pkg::rtc_time_t t_next;
   logic [7:0]         hour_bcd;
   logic [7:0]         hour_inc;
   logic [7:0]         dim;
   logic               sec_c;
   logic               min_c;
   logic               hr_c;
   logic               date_c;
   logic               mon_c;
   logic               yr_c;
   logic               cen_tgl;

   assign hour_bcd = {2'b00, t_reg.hour[5:0]};
   assign hour_inc = bcd_next(hour_bcd, rtc_pkg::HOUR_MAX, rtc_pkg::BCD_ZERO);
   assign dim      = month_days(t_reg.month, t_reg.year);
   assign sec_c    = tick && (t_reg.sec == rtc_pkg::SEC_MAX);
   assign min_c    = sec_c && (t_reg.min == rtc_pkg::MIN_MAX);
   assign hr_c     = min_c && (hour_bcd == rtc_pkg::HOUR_MAX);
   assign date_c   = hr_c && (t_reg.date == dim);
   assign mon_c    = date_c && (t_reg.month == rtc_pkg::MONTH_MAX);
   assign yr_c     = mon_c && (t_reg.year == rtc_pkg::YEAR_MAX);
   assign cen_tgl  = yr_c && t_reg.hour[rtc_pkg::HR_CEN_EN_BIT];

   always_comb begin
      t_next = t_reg;
      t_next.sec = bcd_next(t_reg.sec, rtc_pkg::SEC_MAX,
                            rtc_pkg::BCD_ZERO);
      if (sec_c) begin
         t_next.min = bcd_next(t_reg.min, rtc_pkg::MIN_MAX,
                               rtc_pkg::BCD_ZERO);
      end
      if (min_c) begin
         t_next.hour[5:0] = hour_inc[5:0];
      end
      if (cen_tgl) begin
         t_next.hour[rtc_pkg::HR_CEN_BIT] =
            ~t_reg.hour[rtc_pkg::HR_CEN_BIT];
      end
      if (hr_c) begin
         t_next.day  = bcd_next(t_reg.day, rtc_pkg::DAY_MAX,
                                rtc_pkg::BCD_ONE);
         t_next.date = bcd_next(t_reg.date, dim, rtc_pkg::BCD_ONE);
      end
      if (date_c) begin
         t_next.month = bcd_next(t_reg.month, rtc_pkg::MONTH_MAX,
                                 rtc_pkg::BCD_ONE);
      end
      if (mon_c) begin
         t_next.year = bcd_next(t_reg.year, rtc_pkg::YEAR_MAX,
                                rtc_pkg::BCD_ZERO);
      end
   end

   // ***********************************************************
   // Storage, bus write wins over a tick
   // ***********************************************************
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         t_reg <= rtc_pkg::TIME_RST;
      end else if (wr_en) begin
         t_reg[{wr_addr, 3'b000} +: 8] <=
            wr_data & rtc_pkg::WR_MASK[{wr_addr, 3'b000} +: 8];
      end else if (tick) begin
         t_reg <= t_next;
      end
   end

   assign time_q = t_reg;

endmodule

//--- hw/rtc_pkg.sv
// Constants, types and encodings shared by the calendar clock files
package rtc_pkg;

   // ***********************************************************
   // Oscillator, pin-output and location-count figures
   // ***********************************************************
   localparam int          OSC_FREQ_HZ   = 32768;
   localparam int          SQ_DIV_BITS   = 6;
   localparam int          NUM_LOC       = 8;

   // ***********************************************************
   // Serial bus address and location map
   // ***********************************************************
   localparam logic [7:0]  SLAVE_ADDR_W  = 8'hD0;
   localparam logic [2:0]  ADDR_SEC      = 3'h0;
   localparam logic [2:0]  ADDR_MIN      = 3'h1;
   localparam logic [2:0]  ADDR_HOUR     = 3'h2;
   localparam logic [2:0]  ADDR_DAY      = 3'h3;
   localparam logic [2:0]  ADDR_DATE     = 3'h4;
   localparam logic [2:0]  ADDR_MONTH    = 3'h5;
   localparam logic [2:0]  ADDR_YEAR     = 3'h6;
   localparam logic [2:0]  ADDR_CAL      = 3'h7;
   localparam logic [2:0]  ADDR_LAST_CLK = ADDR_YEAR;

   // ***********************************************************
   // Field positions
   // ***********************************************************
   localparam int          HR_CEN_EN_BIT = 7;
   localparam int          HR_CEN_BIT    = 6;
   localparam int          CAL_OUT_BIT   = 7;
   localparam int          CAL_SQ_BIT    = 6;

   // ***********************************************************
   // BCD limits
   // ***********************************************************
   localparam logic [7:0]  BCD_ONE       = 8'h01;
   localparam logic [7:0]  BCD_ZERO      = 8'h00;
   localparam logic [7:0]  SEC_MAX       = 8'h59;
   localparam logic [7:0]  MIN_MAX       = 8'h59;
   localparam logic [7:0]  HOUR_MAX      = 8'h23;
   localparam logic [7:0]  DAY_MAX       = 8'h07;
   localparam logic [7:0]  MONTH_MAX     = 8'h12;
   localparam logic [7:0]  YEAR_MAX      = 8'h99;
   localparam logic [7:0]  FEB           = 8'h02;
   localparam logic [7:0]  DAYS_LEAP     = 8'h29;
   localparam logic [7:0]  DAYS_FEB      = 8'h28;
   localparam logic [7:0]  DAYS_SHORT    = 8'h30;
   localparam logic [7:0]  DAYS_LONG     = 8'h31;

   // ***********************************************************
   // Stored-bit masks, calibration down to seconds
   // ***********************************************************
   localparam logic [63:0] WR_MASK       = 64'hFF_FF_1F_3F_07_FF_7F_7F;

   // ***********************************************************
   // Reset values, calibration down to seconds
   // ***********************************************************
   localparam logic [63:0] TIME_RST      = 64'h80_00_01_01_01_00_00_00;

   // ***********************************************************
   // Types
   // ***********************************************************
   typedef struct packed {
      logic [7:0] cal;
      logic [7:0] year;
      logic [7:0] month;
      logic [7:0] date;
      logic [7:0] day;
      logic [7:0] hour;
      logic [7:0] min;
      logic [7:0] sec;
   } rtc_time_t;

   typedef struct packed {
      logic scl;
      logic sda;
      logic osc;
      logic pf;
   } rtc_pins_t;

   localparam rtc_pins_t   PINS_RST      = '{scl: 1'b1, sda: 1'b1,
                                             osc: 1'b0, pf: 1'b1};

   typedef enum logic [2:0] {
      SM_IDLE    = 3'b000,
      SM_RX      = 3'b001,
      SM_ACK_OUT = 3'b010,
      SM_TX      = 3'b011,
      SM_ACK_IN  = 3'b100
   } rtc_state_t;

   typedef enum logic [1:0] {
      KIND_ADDR = 2'b00,
      KIND_WORD = 2'b01,
      KIND_DATA = 2'b10
   } rtc_kind_t;

endpackage

//--- hw/rtc_top.sv
// Serial-bus calendar clock: bus slave, pointer, freeze, test pin
`timescale 1ns/1ns
// How it works
// - A 32.768 kHz oscillator input is counted to make a one-second tick.
// - Eight byte locations hold the clock and calendar in BCD.
// - Century, year, month, date, day, hour, minute, second; 24-hour form.
// - The location pointer steps by one after every data byte.
// - Date rolls over by month length with leap February up to 2100.
// - Access is a two-wire serial bus clocked by the master at 400 kHz max.
// - The test/output pin is open drain and only ever pulls low.
// - The block answers only to bus address bytes D0h (write) and D1h (read) after a START.
// - Locations run seconds, minutes, hours, day, date, month, year, cal.
// - The bus copy freezes while pointing at 00h-06h; resumes on STOP/07h.
// - Power fail aborts access, clears the pointer and ignores the bus.
module rtc_top #(
   parameter int OSC_EDGES_PER_SEC = rtc_pkg::OSC_FREQ_HZ
) (
   input  wire logic  mclk,
   input  wire logic  arst_n,
   input  wire logic  scl_i,
   input  wire logic  sda_i,
   output wire logic  sda_o,
   output wire logic  sda_oe,
   input  wire logic  osc_32k_i,
   input  wire logic  below_power_fail_threshold,
   output wire logic  freq_test_output_pin_o,
   output wire logic  freq_test_output_pin_oe
);

   // ***********************************************************
   // Pin synchronisers
   // ***********************************************************
   rtc_pkg::rtc_pins_t pins_raw;
   rtc_pkg::rtc_pins_t meta_reg;
   rtc_pkg::rtc_pins_t sync_reg;
   rtc_pkg::rtc_pins_t prev_reg;

   assign pins_raw = '{scl: scl_i, sda: sda_i, osc: osc_32k_i,
                       pf: below_power_fail_threshold};

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         meta_reg <= rtc_pkg::PINS_RST;
         sync_reg <= rtc_pkg::PINS_RST;
         prev_reg <= rtc_pkg::PINS_RST;
      end else begin
         meta_reg <= pins_raw;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   wire logic scl_rise = sync_reg.scl && !prev_reg.scl;
   wire logic scl_fall = !sync_reg.scl && prev_reg.scl;
   wire logic bus_start = sync_reg.scl && prev_reg.scl &&
                          prev_reg.sda && !sync_reg.sda;
   wire logic bus_stop = sync_reg.scl && prev_reg.scl &&
                         !prev_reg.sda && sync_reg.sda;
   wire logic osc_rise = sync_reg.osc && !prev_reg.osc;
   wire logic pwr_fail = sync_reg.pf;

   // ***********************************************************
   // Oscillator divider
   // ***********************************************************
   localparam logic [15:0] SEC_LAST = 16'(OSC_EDGES_PER_SEC - 1);

   logic [15:0]                     osc_cnt_reg;
   logic [rtc_pkg::SQ_DIV_BITS-1:0] sq_div_reg;
   wire logic sec_tick = osc_rise && (osc_cnt_reg == SEC_LAST);

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         osc_cnt_reg <= 16'h0000;
         sq_div_reg  <= '0;
      end else if (osc_rise) begin
         osc_cnt_reg <= sec_tick ? 16'h0000 : osc_cnt_reg + 16'h0001;
         sq_div_reg  <= sq_div_reg + 1'b1;
      end
   end

   // ***********************************************************
   // Calendar and frozen bus copy
   // ***********************************************************
   rtc_pkg::rtc_time_t  cal_time;
   rtc_pkg::rtc_time_t  snap_reg;
   rtc_pkg::rtc_state_t state_reg;
   rtc_pkg::rtc_kind_t  kind_reg;
   logic [3:0]          cnt_reg;
   logic [7:0]          sh_reg;
   logic [2:0]          ptr_reg;
   logic                rw_reg;
   logic                active_reg;
   logic                sda_oe_reg;
   logic                pin_oe_reg;

   wire logic rx_done = (state_reg == rtc_pkg::SM_RX) && scl_fall &&
                        (cnt_reg == 4'h8);
   wire logic addr_hit = (sh_reg[7:1] == rtc_pkg::SLAVE_ADDR_W[7:1]);
   wire logic cal_wr = !pwr_fail && !bus_start && !bus_stop && rx_done &&
                       (kind_reg == rtc_pkg::KIND_DATA);
   wire logic frozen = active_reg &&
                       (ptr_reg <= rtc_pkg::ADDR_LAST_CLK);
   wire logic [7:0] rd_byte = snap_reg[{ptr_reg, 3'b000} +: 8];

   rtc_calendar u_rtc_calendar (
      .mclk    (mclk),
      .arst_n  (arst_n),
      .tick    (sec_tick),
      .wr_en   (cal_wr),
      .wr_addr (ptr_reg),
      .wr_data (sh_reg),
      .time_q  (cal_time)
   );

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         snap_reg <= rtc_pkg::TIME_RST;
      end else if (!frozen) begin
         snap_reg <= cal_time;
      end
   end

   // ***********************************************************
   // Bus slave state machine
   // ***********************************************************
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg  <= rtc_pkg::SM_IDLE;
         kind_reg   <= rtc_pkg::KIND_ADDR;
         cnt_reg    <= 4'h0;
         sh_reg     <= 8'h00;
         ptr_reg    <= 3'h0;
         rw_reg     <= 1'b0;
         active_reg <= 1'b0;
         sda_oe_reg <= 1'b0;
      end else if (pwr_fail) begin
         state_reg  <= rtc_pkg::SM_IDLE;
         ptr_reg    <= 3'h0;
         active_reg <= 1'b0;
         sda_oe_reg <= 1'b0;
      end else if (bus_start) begin
         state_reg  <= rtc_pkg::SM_RX;
         kind_reg   <= rtc_pkg::KIND_ADDR;
         cnt_reg    <= 4'h0;
         sda_oe_reg <= 1'b0;
      end else if (bus_stop) begin
         state_reg  <= rtc_pkg::SM_IDLE;
         active_reg <= 1'b0;
         sda_oe_reg <= 1'b0;
      end else begin
         case (state_reg)
            rtc_pkg::SM_IDLE: begin
               sda_oe_reg <= 1'b0;
            end
            rtc_pkg::SM_RX: begin
               if (scl_rise && (cnt_reg != 4'h8)) begin
                  sh_reg  <= {sh_reg[6:0], sync_reg.sda};
                  cnt_reg <= cnt_reg + 4'h1;
               end else if (rx_done) begin
                  state_reg  <= rtc_pkg::SM_ACK_OUT;
                  sda_oe_reg <= 1'b1;
                  if (kind_reg == rtc_pkg::KIND_ADDR) begin
                     if (addr_hit) begin
                        rw_reg     <= sh_reg[0];
                        active_reg <= 1'b1;
                     end else begin
                        state_reg  <= rtc_pkg::SM_IDLE;
                        active_reg <= 1'b0;
                        sda_oe_reg <= 1'b0;
                     end
                  end else if (kind_reg == rtc_pkg::KIND_WORD) begin
                     ptr_reg <= sh_reg[2:0];
                  end
               end
            end
            rtc_pkg::SM_ACK_OUT: begin
               if (scl_fall) begin
                  cnt_reg    <= 4'h0;
                  sda_oe_reg <= 1'b0;
                  state_reg  <= rtc_pkg::SM_RX;
                  if ((kind_reg == rtc_pkg::KIND_ADDR) && rw_reg) begin
                     sh_reg     <= rd_byte;
                     sda_oe_reg <= ~rd_byte[7];
                     state_reg  <= rtc_pkg::SM_TX;
                  end else if (kind_reg == rtc_pkg::KIND_ADDR) begin
                     kind_reg <= rtc_pkg::KIND_WORD;
                  end else if (kind_reg == rtc_pkg::KIND_WORD) begin
                     kind_reg <= rtc_pkg::KIND_DATA;
                  end else begin
                     ptr_reg <= ptr_reg + 3'h1;
                  end
               end
            end
            rtc_pkg::SM_TX: begin
               if (scl_fall) begin
                  if (cnt_reg == 4'h7) begin
                     sda_oe_reg <= 1'b0;
                     state_reg  <= rtc_pkg::SM_ACK_IN;
                  end else begin
                     cnt_reg    <= cnt_reg + 4'h1;
                     sh_reg     <= {sh_reg[6:0], 1'b0};
                     sda_oe_reg <= ~sh_reg[6];
                  end
               end
            end
            rtc_pkg::SM_ACK_IN: begin
               if (scl_rise) begin
                  ptr_reg   <= ptr_reg + 3'h1;
                  sh_reg[0] <= sync_reg.sda;
               end else if (scl_fall) begin
                  cnt_reg <= 4'h0;
                  if (!sh_reg[0]) begin
                     sh_reg     <= rd_byte;
                     sda_oe_reg <= ~rd_byte[7];
                     state_reg  <= rtc_pkg::SM_TX;
                  end else begin
                     state_reg <= rtc_pkg::SM_IDLE;
                  end
               end
            end
            default: begin
               state_reg  <= rtc_pkg::SM_IDLE;
               sda_oe_reg <= 1'b0;
            end
         endcase
      end
   end

   // ***********************************************************
   // Open-drain outputs
   // ***********************************************************
   wire logic pin_pull = snap_reg.cal[rtc_pkg::CAL_SQ_BIT] ?
                         ~sq_div_reg[rtc_pkg::SQ_DIV_BITS-1] :
                         ~cal_time.cal[rtc_pkg::CAL_OUT_BIT];

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         pin_oe_reg <= 1'b0;
      end else begin
         pin_oe_reg <= pin_pull;
      end
   end

   assign sda_o                   = 1'b0;
   assign sda_oe                  = sda_oe_reg;
   assign freq_test_output_pin_o  = 1'b0;
   assign freq_test_output_pin_oe = pin_oe_reg;

endmodule

//--- test/rtc_bus_master.sv
// Serial bus master model for the calendar clock
`timescale 1ns/1ns
module rtc_bus_master (
   input  wire logic mclk,
   input  wire logic sda,
   output logic      scl,
   output logic      sda_pull
);
   initial begin
      scl      = 1'b1;
      sda_pull = 1'b0;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge mclk);
   endtask
   // START when b is 1, STOP when b is 0
   task automatic cond(input logic b);
      scl <= 1'b0;
      wt(5);
      sda_pull <= ~b;
      wt(10);
      scl <= 1'b1;
      wt(10);
      sda_pull <= b;
      wt(10);
   endtask
   // 30 mclk a bit, 333 kHz
   task automatic bit_x(input logic b, output logic r);
      scl <= 1'b0;
      wt(5);
      sda_pull <= ~b;
      wt(10);
      scl <= 1'b1;
      wt(7);
      r = sda;
      wt(8);
   endtask
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_x(d[i], r);
      bit_x(1'b1, r);
      ack = ~r;
   endtask
   task automatic rbyte(input logic ack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_x(1'b1, r);
         d[i] = r;
      end
      bit_x(~ack, r);
   endtask
endmodule

//--- test/rtc_props.sv
// Checker on the calendar clock serial and pin ports
`timescale 1ns/1ns
module rtc_props (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe,
   input wire logic osc_32k_i,
   input wire logic below_power_fail_threshold,
   input wire logic freq_test_output_pin_o,
   input wire logic freq_test_output_pin_oe
);
   // *****
   // Bits seen since START
   // *****
   logic [3:0] cnt_reg;
   logic [7:0] sh_reg;
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_reg <= 4'h0;
         sh_reg  <= 8'h00;
      end else if ($fell(sda_i) && scl_i) begin
         cnt_reg <= 4'h0;
      end else if ($rose(scl_i) && cnt_reg != 4'hF) begin
         cnt_reg <= cnt_reg + 4'h1;
         sh_reg  <= {sh_reg[6:0], sda_i};
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);
   sequence s_oe_up; $rose(sda_oe); endsequence
   sequence s_oe_held; sda_oe [*8]; endsequence
   sequence s_pf4; below_power_fail_threshold [*4]; endsequence
   property p_sda_od; sda_o == 1'b0; endproperty
   property p_pin_od; freq_test_output_pin_o == 1'b0; endproperty
   property p_pf_quiet; s_pf4 |-> !sda_oe; endproperty
   property p_oe_scl; $changed(sda_oe) |-> !scl_i; endproperty
   property p_oe_hold; s_oe_up |=> s_oe_held; endproperty
   property p_ack_late; s_oe_up |-> cnt_reg >= 4'h8; endproperty
   property p_addr;
      $rose(sda_oe) && cnt_reg == 4'h8 |-> sh_reg[7:1] == 7'h68;
   endproperty
   property p_ack_due;
      $rose(scl_i) && cnt_reg == 4'h7 && sh_reg[6:0] == 7'h68
         && !below_power_fail_threshold |-> ##[1:40] sda_oe;
   endproperty
   property p_pin_rst;
      $rose(arst_n) |=> !freq_test_output_pin_oe ##1 !freq_test_output_pin_oe;
   endproperty
   a_sda_od: assert property (p_sda_od) else $error("sda high");
   a_pin_od: assert property (p_pin_od) else $error("pin high");
   a_pf_quiet: assert property (p_pf_quiet) else $error("pf drive");
   a_oe_scl: assert property (p_oe_scl) else $error("sda edge");
   a_oe_hold: assert property (p_oe_hold) else $error("sda short");
   a_ack_late: assert property (p_ack_late) else $error("early");
   a_addr: assert property (p_addr) else $error("wrong address");
   a_ack_due: assert property (p_ack_due) else $error("no ack");
   a_pin_rst: assert property (p_pin_rst) else $error("pin rst");
endmodule
bind rtc_top rtc_props u_rtc_props (
   .mclk(mclk), .arst_n(arst_n), .scl_i(scl_i), .sda_i(sda_i),
   .sda_o(sda_o), .sda_oe(sda_oe), .osc_32k_i(osc_32k_i),
   .below_power_fail_threshold(below_power_fail_threshold),
   .freq_test_output_pin_o(freq_test_output_pin_o),
   .freq_test_output_pin_oe(freq_test_output_pin_oe)
);

//--- test/tb_rtc_top.sv
// Self-checking bench of the serial calendar clock
`timescale 1ns/1ns
`define M u_rtc_bus_master
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
   num_errors++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_rtc_top;
   logic        mclk;
   logic        arst_n;
   logic        osc;
   logic        pf;
   wire logic   scl;
   wire logic   pull;
   wire logic   sda;
   wire logic   sda_o;
   wire logic   sda_oe;
   wire logic   pin_oe;
   int          num_errors;
   int          compares;
   int          y, m, d, nd, nm, ny, chg;
   logic [31:0] rs;
   logic [7:0]  hr, dy, eh;
   logic [7:0]  rd_q [8];
   logic [7:0]  wr_q [8];
   logic        ack, lv;
   assign sda = ~((sda_oe & ~sda_o) | pull);
   rtc_top #(.OSC_EDGES_PER_SEC(1000)) u_rtc_top (
      .mclk(mclk), .arst_n(arst_n), .scl_i(scl), .sda_i(sda),
      .sda_o(sda_o), .sda_oe(sda_oe), .osc_32k_i(osc),
      .below_power_fail_threshold(pf), .freq_test_output_pin_o(),
      .freq_test_output_pin_oe(pin_oe));
   rtc_bus_master u_rtc_bus_master (
      .mclk(mclk), .sda(sda), .scl(scl), .sda_pull(pull));
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   initial begin
      osc = 1'b0;
      #137;
      forever #400 osc = ~osc;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   function automatic logic [7:0] bcd(input int v);
      return 8'((v / 10) * 16 + v % 10);
   endfunction
   function automatic int mdays(input int mo, input int yr);
      if (mo == 2) return (yr % 4 == 0) ? 29 : 28;
      return (mo == 4 || mo == 6 || mo == 9 || mo == 11) ? 30 : 31;
   endfunction
   task automatic set_ptr(input logic [2:0] p);
      `M.cond(1'b1);
      `M.wbyte(8'hD0, ack);
      `CHK("addr ack", 1'b1, ack)
      `M.wbyte({5'h00, p}, ack);
   endtask
   task automatic wr_seq(input logic [2:0] p, input int n);
      set_ptr(p);
      for (int i = 0; i < n; i++) `M.wbyte(wr_q[i], ack);
      `M.cond(1'b0);
   endtask
   task automatic rd_seq(input int n);
      set_ptr(3'h0);
      `M.cond(1'b1);
      `M.wbyte(8'hD1, ack);
      for (int i = 0; i < n; i++) `M.rbyte(i != n - 1, rd_q[i]);
      `M.cond(1'b0);
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (98000) @(posedge mclk);
      num_errors++;
      $display("[FAIL] run exp done got timeout");
      final_report();
   end
   initial begin
      num_errors = 0;
      compares = 0;
      rs = 32'd93148;
      arst_n = 1'b0;
      pf = 1'b0;
      repeat (10) @(posedge mclk);
      arst_n <= 1'b1;
      repeat (20) @(posedge mclk);
      rs = xs(rs);
      `M.cond(1'b1);
      `M.wbyte((rs[7:1] == 7'h68) ? 8'hA0 : rs[7:0], ack);
      `CHK("foreign ack", 1'b0, ack)
      `M.cond(1'b0);
      $display("test foreign address done");
      rd_seq(8);
      for (int i = 0; i < 8; i++)
         `CHK("reset loc", rtc_pkg::TIME_RST[i*8+:8], rd_q[i])
      $display("test reset contents done");
      for (int k = 0; k < 4; k++) begin
         rs = xs(rs);
         y = (k == 0) ? 24 : (k == 1) ? 99 : int'(rs[7:0]) % 100;
         m = (k == 0) ? 2 : (k == 1) ? 12 : int'(rs[15:8]) % 12 + 1;
         d = mdays(m, y) - ((k == 0) ? 1 : 0);
         hr = (k == 1) ? 8'hA3 : 8'h23;
         dy = 8'(int'(rs[18:16]) % 7 + 1);
         wr_q[0] = 8'h59;
         wr_q[1] = hr;
         wr_q[2] = dy;
         wr_q[3] = bcd(d);
         wr_q[4] = bcd(m);
         wr_q[5] = bcd(y);
         wr_seq(3'h1, 6);
         wr_seq(3'h0, 1);
         repeat (10000) @(posedge mclk);
         rd_seq(7);
         nd = (d == mdays(m, y)) ? 1 : d + 1;
         nm = (nd != 1) ? m : (m == 12) ? 1 : m + 1;
         ny = (nd == 1 && m == 12) ? (y + 1) % 100 : y;
         eh = {hr[7], hr[6] ^ (hr[7] && y == 99 && ny == 0), 6'h00};
         `CHK("sec", 8'h00, rd_q[0] & 8'hFE)
         `CHK("min", 8'h00, rd_q[1])
         `CHK("hour", eh, rd_q[2])
         `CHK("day", (dy == 8'h07) ? 8'h01 : dy + 8'h01, rd_q[3])
         `CHK("date", bcd(nd), rd_q[4])
         `CHK("month", bcd(nm), rd_q[5])
         `CHK("year", bcd(ny), rd_q[6])
      end
      $display("test rollover done");
      wr_q[0] = 8'h30;
      wr_seq(3'h0, 1);
      set_ptr(3'h0);
      repeat (9000) @(posedge mclk);
      rd_seq(1);
      eh = rd_q[0];
      `CHK("frozen sec", 8'h30, eh & 8'hFE)
      rd_seq(1);
      `CHK("sec thawed", 1'b1, rd_q[0] != eh)
      $display("test freeze done");
      wr_q[0] = 8'h00;
      wr_seq(3'h7, 1);
      repeat (5) @(posedge mclk);
      `CHK("pin low", 1'b1, pin_oe)
      wr_q[0] = 8'hC0;
      wr_seq(3'h7, 1);
      chg = 0;
      for (int i = 0; i < 1100; i++) begin
         lv = pin_oe;
         @(posedge mclk);
         if (pin_oe !== lv) chg++;
      end
      `CHK("pin toggles", 1'b1, chg >= 4 && chg <= 5)
      wr_q[0] = 8'h80;
      wr_seq(3'h7, 1);
      repeat (5) @(posedge mclk);
      `CHK("pin off", 1'b0, pin_oe)
      $display("test output pin done");
      wr_seq(3'h7, 0);
      pf <= 1'b1;
      repeat (10) @(posedge mclk);
      `M.cond(1'b1);
      `M.wbyte(8'hD0, ack);
      `CHK("pf ack", 1'b0, ack)
      `M.cond(1'b0);
      pf <= 1'b0;
      repeat (10) @(posedge mclk);
      `M.cond(1'b1);
      `M.wbyte(8'hD1, ack);
      `M.rbyte(1'b0, rd_q[0]);
      `M.cond(1'b0);
      `CHK("ptr cleared", 1'b0, rd_q[0][7])
      $display("test power fail done");
      final_report();
   end
endmodule
